// *** verilog/ppio_pkg.sv ***
// Package: register map, reset values and carriers for the dual port I/O block
package ppio_pkg;
	localparam int unsigned PPIO_W = 8;
	// Register byte offsets
	localparam logic [7:0] PPIO_OFF_PULLUP = 8'h00;
	localparam logic [7:0] PPIO_OFF_OPTION = 8'h04;
	localparam logic [7:0] PPIO_OFF_FP_DATA = 8'h08;
	localparam logic [7:0] PPIO_OFF_FP_DIR = 8'h0C;
	localparam logic [7:0] PPIO_OFF_SP_DATA = 8'h10;
	localparam logic [7:0] PPIO_OFF_SP_DIR = 8'h14;
	localparam logic [7:0] PPIO_OFF_ALT_FP = 8'h18;
	localparam logic [7:0] PPIO_OFF_ALT_SP = 8'h1C;
	localparam logic [7:0] PPIO_OFF_PULL_STAT = 8'h20;
	// Reset values
	localparam logic [7:0] PPIO_RST_ONES = 8'hFF;
	localparam logic [7:0] PPIO_RST_ZERO = 8'h00;
	localparam logic PPIO_RST_GPD_N = 1'b1;
	// Bit of the option register holding the global pull-up disable
	localparam int unsigned PPIO_GPD_BIT = 0;
	// Second-port pins whose alternate function is an analog bias input
	localparam logic [7:0] PPIO_SP_BIAS_PINS = 8'h07;
	// Pin group carried between the block and pad ring
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} ppio_drive_type;
	// Alternate function request from peripherals for one port
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] o;
		logic [7:0] oe;
	} ppio_alt_type;
endpackage : ppio_pkg

// *** verilog/ppio_sync.sv ***
// Two flip-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module ppio_sync import ppio_pkg::*; #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	// Elaboration guard: an empty bank has nothing to synchronise
	if (W < 1) begin : g_bad_width
		$error("synchroniser width must be at least one");
	end
	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : ppio_sync

// *** verilog/ppio_port.sv ***
// Top: two 8-bit I/O ports, weak pull-ups on the first, alternate function muxing, APB registers
`timescale 1ns/1ps
// Behaviour
// - One pull-up enable bit per first-port pin, one enables.
// - Pull-ups only act when global pull-up control enables them.
// - Pull-up forced off on any first-port pin set as output.
// - Global pull-up control is active low and resets to disabled.
// - Second port is eight bits, bidirectional, Schmitt inputs, shared pins.
// - Writing second-port data updates latch, driven on output pins.
// - Reading second-port data returns present pin levels.
// - Second-port direction one is input high-Z, zero drives latch.
// - First-port direction one is high-Z input, zero is output.
// - First pin 0 is GPIO, external interrupt input, or LCD segment.
// - First pins 1-5 are GPIO or LCD segment/common, LCD replaces driver.
// - First pin 6 is GPIO, programming clock, debugger clock, or segment.
// - First pin 7 is GPIO, programming data, debugger data, or segment.
// - Second pins 0-2 are GPIO or analog LCD bias input.
// - Second pin 4 is GPIO, timer gate, serial data out, or segment.
// - Second pin 5 is GPIO, timer clock, capture/compare/PWM, or segment.
// - Second pin 3 is GPIO or LCD segment.
module ppio_port import ppio_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] first_port_in,
	output logic [7:0] first_port_out,
	output logic [7:0] first_port_oe,
	output logic [7:0] first_port_pullup,
	input wire logic [7:0] second_port_in,
	output logic [7:0] second_port_out,
	output logic [7:0] second_port_oe,
	input wire ppio_alt_type first_alt,
	input wire ppio_alt_type second_alt,
	output logic [7:0] first_port_sync,
	output logic [7:0] second_port_sync
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] pullup_enable_bits_r;
	logic global_pullup_disable_n_r;
	logic [7:0] first_port_data_r;
	logic [7:0] first_port_direction_r;
	logic [7:0] second_port_data_r;
	logic [7:0] second_port_direction_r;
	logic [7:0] fp_sync;
	logic [7:0] sp_sync;
	logic wr_en;
	logic rd_en;
	logic [31:0] rdata_nxt;
	logic addr_ok;
	ppio_drive_type fp_nxt;
	ppio_drive_type sp_nxt;
	logic [7:0] pull_nxt;

	// Pin levels pass two flops before any register read sees them
	ppio_sync #(.W(PPIO_W)) u_sync_fp (
		.pclk(pclk),
		.presetn(presetn),
		.d(first_port_in),
		.q(fp_sync)
	);
	ppio_sync #(.W(PPIO_W)) u_sync_sp (
		.pclk(pclk),
		.presetn(presetn),
		.d(second_port_in),
		.q(sp_sync)
	);

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == PPIO_OFF_PULLUP) || (a == PPIO_OFF_OPTION) ||
			(a == PPIO_OFF_FP_DATA) || (a == PPIO_OFF_FP_DIR) ||
			(a == PPIO_OFF_SP_DATA) || (a == PPIO_OFF_SP_DIR) ||
			(a == PPIO_OFF_ALT_FP) || (a == PPIO_OFF_ALT_SP) ||
			(a == PPIO_OFF_PULL_STAT);
	endfunction : known_addr

	// ****************************************
	// APB slave
	// ****************************************
	// One-wait-state access; pready is registered so it pulses in the second access cycle
	assign addr_ok = known_addr(paddr);
	assign wr_en = psel && penable && pready && pwrite && addr_ok;
	assign rd_en = psel && penable && !pready && !pwrite;

	// Access phase takes two cycles: one to assert pready, one to complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
		end
	end

	// Configuration registers reset to ones; read-only addresses ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_enable_bits_r <= PPIO_RST_ONES;
			first_port_direction_r <= PPIO_RST_ONES;
			second_port_direction_r <= PPIO_RST_ONES;
			global_pullup_disable_n_r <= PPIO_RST_GPD_N;
		end else if (wr_en) begin
			unique case (paddr)
				PPIO_OFF_PULLUP: pullup_enable_bits_r <= pwdata[7:0];
				PPIO_OFF_OPTION: global_pullup_disable_n_r <= pwdata[PPIO_GPD_BIT];
				PPIO_OFF_FP_DIR: first_port_direction_r <= pwdata[7:0];
				PPIO_OFF_SP_DIR: second_port_direction_r <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Output latches have no reset: their power-up value is undefined by design
	always_ff @(posedge pclk) begin
		if (wr_en && paddr == PPIO_OFF_FP_DATA) begin
			first_port_data_r <= pwdata[7:0];
		end
		if (wr_en && paddr == PPIO_OFF_SP_DATA) begin
			second_port_data_r <= pwdata[7:0];
		end
	end

	// Data reads return pin levels, not latches
	always_comb begin
		rdata_nxt = '0;
		unique case (paddr)
			PPIO_OFF_PULLUP: rdata_nxt[7:0] = pullup_enable_bits_r;
			PPIO_OFF_OPTION: rdata_nxt[PPIO_GPD_BIT] = global_pullup_disable_n_r;
			PPIO_OFF_FP_DATA: rdata_nxt[7:0] = fp_sync;
			PPIO_OFF_FP_DIR: rdata_nxt[7:0] = first_port_direction_r;
			PPIO_OFF_SP_DATA: rdata_nxt[7:0] = sp_sync;
			PPIO_OFF_SP_DIR: rdata_nxt[7:0] = second_port_direction_r;
			PPIO_OFF_ALT_FP: rdata_nxt[7:0] = first_alt.sel;
			PPIO_OFF_ALT_SP: rdata_nxt[7:0] = second_alt.sel;
			PPIO_OFF_PULL_STAT: rdata_nxt[7:0] = first_port_pullup;
			default: rdata_nxt = '0;
		endcase
	end

	// Read data captured in the first access cycle, held through completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_en) begin
			prdata <= rdata_nxt;
		end
	end

	// ****************************************
	// Pin muxing
	// ****************************************
	// An alternate function that owns a pin replaces latch and direction.
	// Bit 0 interrupt, bits 1-5 LCD, bits 6-7 programming/debug/LCD on the first port.
	always_comb begin
		for (int i = 0; i < PPIO_W; i++) begin
			fp_nxt.o[i] = first_alt.sel[i] ? first_alt.o[i] : first_port_data_r[i];
			fp_nxt.oe[i] = first_alt.sel[i] ? first_alt.oe[i]
				: !first_port_direction_r[i];
			// Bias pins are analog inputs when claimed: driver always off
			sp_nxt.o[i] = second_alt.sel[i] ? second_alt.o[i] : second_port_data_r[i];
			sp_nxt.oe[i] = second_alt.sel[i] ? (second_alt.oe[i] && !PPIO_SP_BIAS_PINS[i])
				: !second_port_direction_r[i];
		end
	end

	// Pull-up needs per-pin enable, global enable (low) and a non-driving pin
	always_comb begin
		for (int i = 0; i < PPIO_W; i++) begin
			pull_nxt[i] = pullup_enable_bits_r[i] && !global_pullup_disable_n_r
				&& !fp_nxt.oe[i];
		end
	end

	// All pad outputs are registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_port_out <= PPIO_RST_ZERO;
			first_port_oe <= PPIO_RST_ZERO;
			second_port_out <= PPIO_RST_ZERO;
			second_port_oe <= PPIO_RST_ZERO;
			first_port_pullup <= PPIO_RST_ZERO;
			first_port_sync <= PPIO_RST_ZERO;
			second_port_sync <= PPIO_RST_ZERO;
		end else begin
			first_port_out <= fp_nxt.o;
			first_port_oe <= fp_nxt.oe;
			second_port_out <= sp_nxt.o;
			second_port_oe <= sp_nxt.oe;
			first_port_pullup <= pull_nxt;
			first_port_sync <= fp_sync;
			second_port_sync <= sp_sync;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_apb_write(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence

	a_pullup_global_off: assert property (@(posedge pclk) disable iff (!presetn)
		global_pullup_disable_n_r |=> first_port_pullup == 8'h00)
		else $error("pull-up on while globally disabled");
	a_pullup_output_off: assert property (@(posedge pclk) disable iff (!presetn)
		(first_port_oe & first_port_pullup) == 8'h00)
		else $error("pull-up on a driven pin");
	a_pullup_enable_on: assert property (@(posedge pclk) disable iff (!presetn)
		(!global_pullup_disable_n_r && first_alt.sel == 8'h00 && first_port_direction_r == 8'hFF)
		|=> first_port_pullup == $past(pullup_enable_bits_r))
		else $error("pull-up does not follow enable bits");
	a_sp_latch_drive: assert property (@(posedge pclk) disable iff (!presetn)
		s_apb_write(PPIO_OFF_SP_DATA) ##1 (second_alt.sel == 8'h00)[*2]
		|-> ((second_port_out ^ $past(pwdata[7:0], 2)) & second_port_oe) == 8'h00)
		else $error("second-port latch not driven");
	a_sp_dir_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		(second_alt.sel == 8'h00) |=> second_port_oe == ~$past(second_port_direction_r))
		else $error("second-port direction wrong");
	a_fp_dir_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		(first_alt.sel == 8'h00) |=> first_port_oe == ~$past(first_port_direction_r))
		else $error("first-port direction wrong");
	a_bias_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
		((second_alt.sel & PPIO_SP_BIAS_PINS) == PPIO_SP_BIAS_PINS)
		|=> (second_port_oe & PPIO_SP_BIAS_PINS) == 8'h00)
		else $error("bias pin driven");
	a_alt_override: assert property (@(posedge pclk) disable iff (!presetn)
		(first_alt.sel == 8'hFF) |=> first_port_oe == $past(first_alt.oe)
		&& first_port_out == $past(first_alt.o))
		else $error("alternate function not overriding");
	a_sp_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PPIO_OFF_SP_DATA) |=> prdata[7:0] == $past(sp_sync) && pready)
		else $error("second-port read not pin level");
	a_option_reset: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> global_pullup_disable_n_r)
		else $error("global pull-up not disabled after reset");

	// ****************************************
	// Pin ownership, latch, read-back, reset and pull-up checks
	// ****************************************
	// A pin handed to a peripheral follows that peripheral one cycle later.
	// Limitation: keep alternate selects idle over a reset release, pads sit at reset one edge.
	property p_pin_owned(logic sel_b, logic oe_b, logic o_b, logic oe_now, logic out_now);
		@(posedge pclk) disable iff (!presetn)
		sel_b |=> oe_now == $past(oe_b) && out_now == $past(o_b);
	endproperty
	// First port: interrupt/segment pin 0, programming/debug pins 6 and 7
	a_fp_pin0_owned: assert property (p_pin_owned(first_alt.sel[0],
		first_alt.oe[0], first_alt.o[0], first_port_oe[0], first_port_out[0]))
		else $error("first-port pin 0 not owned by its peripheral");
	a_fp_pin6_owned: assert property (p_pin_owned(first_alt.sel[6],
		first_alt.oe[6], first_alt.o[6], first_port_oe[6], first_port_out[6]))
		else $error("first-port pin 6 not owned by its peripheral");
	a_fp_pin7_owned: assert property (p_pin_owned(first_alt.sel[7],
		first_alt.oe[7], first_alt.o[7], first_port_oe[7], first_port_out[7]))
		else $error("first-port pin 7 not owned by its peripheral");
	// Second port: bias pins are left out, they only take analog levels when claimed
	a_sp_pin3_owned: assert property (p_pin_owned(second_alt.sel[3],
		second_alt.oe[3], second_alt.o[3], second_port_oe[3], second_port_out[3]))
		else $error("second-port pin 3 not owned by its peripheral");
	a_sp_pin4_owned: assert property (p_pin_owned(second_alt.sel[4],
		second_alt.oe[4], second_alt.o[4], second_port_oe[4], second_port_out[4]))
		else $error("second-port pin 4 not owned by its peripheral");
	a_sp_pin5_owned: assert property (p_pin_owned(second_alt.sel[5],
		second_alt.oe[5], second_alt.o[5], second_port_oe[5], second_port_out[5]))
		else $error("second-port pin 5 not owned by its peripheral");
	a_fp_seg_owned: assert property (@(posedge pclk) disable iff (!presetn)
		(first_alt.sel[5:1] == 5'h1F) |=> first_port_oe[5:1] == $past(first_alt.oe[5:1])
		&& first_port_out[5:1] == $past(first_alt.o[5:1]))
		else $error("segment pins not owned by the display driver");
	a_fp_latch_drive: assert property (@(posedge pclk) disable iff (!presetn)
		s_apb_write(PPIO_OFF_FP_DATA) ##1 (first_alt.sel == 8'h00)[*2]
		|-> ((first_port_out ^ $past(pwdata[7:0], 2)) & first_port_oe) == 8'h00)
		else $error("first-port latch not driven");
	a_fp_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PPIO_OFF_FP_DATA) |=> prdata[7:0] == $past(fp_sync))
		else $error("first-port read not pin level");
	a_cfg_reset_ones: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> pullup_enable_bits_r == PPIO_RST_ONES
		&& first_port_direction_r == PPIO_RST_ONES && second_port_direction_r == PPIO_RST_ONES)
		else $error("configuration not at reset value");
	a_pullup_dir_track: assert property (@(posedge pclk) disable iff (!presetn)
		(first_alt.sel == 8'h00)
		|=> (first_port_pullup & ~$past(first_port_direction_r)) == 8'h00)
		else $error("pull-up on an output pin");
	a_pullup_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
		(pullup_enable_bits_r != PPIO_RST_ONES)
		|=> (first_port_pullup & ~$past(pullup_enable_bits_r)) == 8'h00)
		else $error("pull-up on a pin whose enable is clear");
	a_option_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PPIO_OFF_OPTION)
		|=> prdata[PPIO_GPD_BIT] == $past(global_pullup_disable_n_r))
		else $error("global pull-up control read wrong");
endmodule : ppio_port

// *** bench/ppio_pins.sv ***
// Pad ring model: resolves each pin level from the block's drivers and the board
`timescale 1ns/1ps
module ppio_pins (
	input wire logic [7:0] drv_o,
	input wire logic [7:0] drv_oe,
	input wire logic [7:0] pull,
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// ***************
	// Pin resolution
	// ***************
	// The block's driver wins, then the weak pull-up, then the board's own level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin[i] = drv_oe[i] ? drv_o[i] : (pull[i] ? 1'b1 : ext[i]);
		end
	end
endmodule : ppio_pins

// *** bench/tb_top.sv ***
// Self-checking bench for the dual port I/O block
`timescale 1ns/1ps
module tb_top import ppio_pkg::*; ;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} ppio_row_type;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, ext_fp = 8'h00, ext_sp = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr;
	logic [7:0] fp_in, fp_out, fp_oe, fp_pu, sp_in, sp_out, sp_oe, fp_syn, sp_syn;
	ppio_alt_type first_alt = '0, second_alt = '0;
	int fail_count = 0, check_count = 0;
	ppio_row_type rows [5] = '{'{8'h00, 32'hA5, 32'hA5}, '{8'h0C, 32'h0F, 32'h0F},
		'{8'h14, 32'hF0, 32'hF0}, '{8'h04, 32'h00, 32'h00}, '{8'h18, 32'hFF, 32'h00}};
	ppio_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_port_in(fp_in), .first_port_out(fp_out),
		.first_port_oe(fp_oe), .first_port_pullup(fp_pu), .second_port_in(sp_in),
		.second_port_out(sp_out), .second_port_oe(sp_oe), .first_alt(first_alt),
		.second_alt(second_alt), .first_port_sync(fp_syn), .second_port_sync(sp_syn));
	ppio_pins PINS_A (.drv_o(fp_out), .drv_oe(fp_oe), .pull(fp_pu), .ext(ext_fp), .pin(fp_in));
	ppio_pins PINS_B (.drv_o(sp_out), .drv_oe(sp_oe), .pull(8'h00), .ext(ext_sp), .pin(sp_in));
	// ***************
	// Clock
	// ***************
	initial begin
		forever #4 pclk = ~pclk;
	end
	// ***************
	// Tasks
	// ***************
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// Compare one value; an unknown never counts as a match
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer; the wait for pready is bounded so a dead slave cannot hang us
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] q, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			finish_test();
		end
		if (!w) chk("prdata", q, prdata);
		chk("pslverr", {31'h0, err}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	// Power-on values of the register bank and the pull-up pins
	task automatic reset_values();
		acc(1'b0, 8'h00, 32'h0, 32'hFF, 1'b0);
		acc(1'b0, 8'h0C, 32'h0, 32'hFF, 1'b0);
		acc(1'b0, 8'h14, 32'h0, 32'hFF, 1'b0);
		acc(1'b0, 8'h04, 32'h0, 32'h01, 1'b0);
		chk("pullup", 32'h0, {24'h0, fp_pu});
	endtask : reset_values
	// ***************
	// Main sequence
	// ***************
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		reset_values();
		// Register cases: write then read back; the read-only alternate select row reads 00
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].d, 32'h0, 1'b0);
			acc(1'b0, rows[i].a, 32'h0, rows[i].q, 1'b0);
		end
		repeat (2) @(posedge pclk);
		// Global enable on: only input pins keep their pull-up
		chk("pullup", 32'h05, {24'h0, fp_pu});
		chk("fp_oe", 32'hF0, {24'h0, fp_oe});
		acc(1'b1, 8'h04, 32'h1, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		chk("pullup", 32'h00, {24'h0, fp_pu});
		// Latches drive only output pins; a read shows the mixed pin levels
		ext_sp <= 8'h5A;
		ext_fp <= 8'h0A;
		acc(1'b1, 8'h10, 32'h3C, 32'h0, 1'b0);
		acc(1'b1, 8'h08, 32'h3C, 32'h0, 1'b0);
		repeat (6) @(posedge pclk);
		chk("sp_oe", 32'h0F, {24'h0, sp_oe});
		chk("sp_out", 32'h0C, {24'h0, sp_out & sp_oe});
		chk("fp_out", 32'h30, {24'h0, fp_out & fp_oe});
		chk("sp_sync", 32'h5C, {24'h0, sp_syn});
		chk("fp_sync", 32'h3A, {24'h0, fp_syn});
		acc(1'b0, 8'h10, 32'h0, 32'h5C, 1'b0);
		acc(1'b0, 8'h08, 32'h0, 32'h3A, 1'b0);
		// Peripherals take pins over; bias pins lose their driver
		first_alt <= '{sel: 8'h81, o: 8'h80, oe: 8'h81};
		second_alt <= '{sel: 8'h3F, o: 8'h30, oe: 8'h3F};
		repeat (2) @(posedge pclk);
		chk("fp_oe", 32'hF1, {24'h0, fp_oe});
		chk("fp_out", 32'h80, {24'h0, fp_out & 8'h81});
		chk("sp_oe", 32'h38, {24'h0, sp_oe});
		chk("sp_out", 32'h30, {24'h0, sp_out & 8'h38});
		acc(1'b1, 8'h18, 32'h00, 32'h0, 1'b0);
		acc(1'b0, 8'h18, 32'h0, 32'h81, 1'b0);
		acc(1'b0, 8'h1C, 32'h0, 32'h3F, 1'b0);
		// Unmapped address is refused
		acc(1'b1, 8'h24, 32'hFF, 32'h0, 1'b1);
		acc(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
		// Every first-port pin owned by peripherals, then all handed back
		first_alt <= '{sel: 8'hFF, o: 8'h5A, oe: 8'h3C};
		repeat (2) @(posedge pclk);
		chk("fp_oe", 32'h3C, {24'h0, fp_oe});
		chk("fp_out", 32'h5A, {24'h0, fp_out});
		first_alt <= '0;
		second_alt <= '0;
		// Second reset in mid-run; selects idle so the release edge stays quiet
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		reset_values();
		// Global enable with every pin an input: each enable bit reaches its pin
		acc(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		chk("pullup", 32'hFF, {24'h0, fp_pu});
		finish_test();
	end
endmodule : tb_top
